// [rtl/ucm_channel.sv]
// Channel mode registers, FIFO level bidding and vectored acknowledge for one channel.
//
// The address map and register access over APB were left to the implementer.
module ucm_channel #(
  parameter logic [1:0] CHANNEL = 2'h0
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_err,
  input wire logic i_rx_start,
  input wire logic i_tx_take,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_int_ack_strobe_n,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  output logic o_bus_ack_pulse_n,
  output logic o_int_req,
  output logic o_rx_bid,
  output logic o_tx_bid,
  output logic [7:0] o_latched_winner_reg,
  output logic o_request_to_send_out_n,
  output logic o_rx_enabled,
  output logic o_tx_enabled,
  output logic o_watchdog_en,
  output logic o_rx_err,
  output logic [1:0] o_parity_mode,
  output logic o_parity_odd,
  output logic [3:0] o_char_bits,
  output logic [1:0] o_channel_mode,
  output logic o_tx_send_request_control,
  output logic o_cts_enable,
  output logic [5:0] o_stop_sixteenths,
  output logic [3:0] o_rx_clk_select,
  output logic [3:0] o_tx_clk_select
);
  import ucm_pkg::*;

  typedef enum logic [1:0] {ACK_IDLE, ACK_DRIVE, ACK_HOLD} ucm_ack_t;

  typedef struct packed {
    logic [3:0] mr0_hi;
    logic [7:0] mr1;
    logic [7:0] mr2;
    logic [7:0] clksel;
    logic [7:0] icw;
    logic [7:0] vbase;
    logic [1:0] ptr;
    logic rx_en;
    logic tx_en;
    logic [FIFO_DEPTH-1:0][8:0] rx_mem;
    logic [2:0] rx_wp;
    logic [2:0] rx_rp;
    logic [3:0] rx_cnt;
    logic [FIFO_DEPTH-1:0][7:0] tx_mem;
    logic [2:0] tx_wp;
    logic [2:0] tx_rp;
    logic [3:0] tx_cnt;
    logic err_sticky;
    logic rts_n;
    logic rts_auto;
    logic [7:0] winner;
    logic [31:0] prdata;
    logic ack_s1;
    logic ack_s2;
    logic ack_q;
    ucm_ack_t ack_state;
    logic [7:0] data;
    logic data_oe_n;
    logic ack_n;
    logic int_req;
  } ucm_state_t;

  ucm_state_t st_r;
  ucm_state_t st_nxt;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic rx_push;
  logic rx_pop;
  logic tx_push;
  logic tx_pop;
  logic [3:0] tx_free;
  logic rx_level_ok;
  logic tx_level_ok;
  logic [7:0] rx_bid_val;
  logic [7:0] tx_bid_val;
  logic [7:0] win_val;
  logic any_bid;
  logic above;
  logic [7:0] win_latch;
  logic [7:0] vector;
  logic [3:0] cmd;

  always_comb begin
    mapped = (i_paddr == OFS_MODE) || (i_paddr == OFS_CLKSEL) || (i_paddr == OFS_CMD)
      || (i_paddr == OFS_ICW) || (i_paddr == OFS_VBASE) || (i_paddr == OFS_STATUS)
      || (i_paddr == OFS_TXDATA) || (i_paddr == OFS_RXDATA) || (i_paddr == OFS_WINNER);
    setup = i_psel && !i_penable;
    wr_acc = i_psel && i_penable && i_pwrite && mapped;
    rd_acc = i_psel && i_penable && !i_pwrite && mapped;
    tx_free = FIFO_FULL - st_r.tx_cnt;
    // Levels only gate the bid; the FIFOs themselves always take eight bytes.
    case ({st_r.mr0_hi[2], st_r.mr1[6]})
      2'b00: rx_level_ok = st_r.rx_cnt != 4'h0;
      2'b01: rx_level_ok = st_r.rx_cnt >= RX_LVL_3;
      2'b10: rx_level_ok = st_r.rx_cnt >= RX_LVL_6;
      default: rx_level_ok = st_r.rx_cnt == FIFO_FULL;
    endcase
    case (st_r.mr0_hi[1:0])
      2'b00: tx_level_ok = tx_free == FIFO_FULL;
      2'b01: tx_level_ok = tx_free >= TX_LVL_4;
      2'b10: tx_level_ok = tx_free >= TX_LVL_6;
      default: tx_level_ok = tx_free != 4'h0;
    endcase
    rx_bid_val = {3'(st_r.rx_cnt - 4'h1), o_rx_err, TYPE_RX_LOW, CHANNEL};
    tx_bid_val = {1'b0, 2'(tx_free[2:0] - 3'h1 >> 1), TYPE_TX, CHANNEL};
    if (o_rx_bid && (!o_tx_bid || rx_bid_val > tx_bid_val)) begin
      win_val = rx_bid_val;
    end else begin
      win_val = tx_bid_val;
    end
    any_bid = o_rx_bid || o_tx_bid;
    above = any_bid && (win_val[7:2] > st_r.icw[7:2]);
    win_latch = above ? win_val : NO_WINNER;
    case (st_r.icw[1:0])
      VFMT_BASE: vector = st_r.vbase;
      VFMT_CHAN: vector = {st_r.vbase[7:2], win_latch[1:0]};
      VFMT_TYPE: vector = {st_r.vbase[7:5], win_latch[4:0]};
      default: vector = st_r.vbase;
    endcase
    cmd = i_pwdata[7:4];
    rx_pop = rd_acc && (i_paddr == OFS_RXDATA) && (st_r.rx_cnt != 4'h0);
    rx_push = i_rx_valid && st_r.rx_en && ((st_r.rx_cnt != FIFO_FULL) || rx_pop);
    tx_pop = i_tx_take && (st_r.tx_cnt != 4'h0);
    tx_push = wr_acc && (i_paddr == OFS_TXDATA) && st_r.tx_en
      && (st_r.tx_cnt != FIFO_FULL);

    st_nxt = st_r;
    st_nxt.ack_s1 = i_int_ack_strobe_n;
    st_nxt.ack_s2 = st_r.ack_s1;
    st_nxt.ack_q = st_r.ack_s2;
    st_nxt.int_req = above;
    // Read data is captured in the setup phase so the bus sees a flopped value.
    if (setup) begin
      case (i_paddr)
        OFS_MODE: begin
          case (st_r.ptr)
            2'h0: st_nxt.prdata = {24'h0, st_r.mr0_hi, MR0_LOW_READ};
            2'h1: st_nxt.prdata = {24'h0, st_r.mr1};
            default: st_nxt.prdata = {24'h0, st_r.mr2};
          endcase
        end
        OFS_CLKSEL: st_nxt.prdata = {24'h0, st_r.clksel};
        OFS_ICW: st_nxt.prdata = {24'h0, st_r.icw};
        OFS_VBASE: st_nxt.prdata = {24'h0, st_r.vbase};
        OFS_STATUS: st_nxt.prdata = {24'h0, o_rx_err, st_r.rx_cnt == FIFO_FULL,
          st_r.rx_cnt != 4'h0, st_r.tx_cnt == 4'h0, st_r.tx_cnt != FIFO_FULL,
          st_r.rx_en, st_r.tx_en, st_r.rts_n};
        OFS_RXDATA: st_nxt.prdata = {24'h0, st_r.rx_mem[st_r.rx_rp][7:0]};
        OFS_WINNER: st_nxt.prdata = {24'h0, st_r.winner};
        default: st_nxt.prdata = 32'h0000_0000;
      endcase
    end
    if (i_psel && i_penable && mapped && (i_paddr == OFS_MODE)) begin
      if (i_pwrite) begin
        case (st_r.ptr)
          2'h0: st_nxt.mr0_hi = i_pwdata[7:4];
          2'h1: st_nxt.mr1 = i_pwdata[7:0];
          default: st_nxt.mr2 = i_pwdata[7:0];
        endcase
      end
      if (st_r.ptr != PTR_LAST) begin
        st_nxt.ptr = st_r.ptr + 2'h1;
      end
    end
    if (wr_acc) begin
      case (i_paddr)
        OFS_CLKSEL: st_nxt.clksel = i_pwdata[7:0];
        OFS_ICW: st_nxt.icw = i_pwdata[7:0];
        OFS_VBASE: st_nxt.vbase = i_pwdata[7:0];
        default: st_nxt.clksel = st_nxt.clksel;
      endcase
    end
    if (rx_pop) begin
      st_nxt.rx_rp = st_r.rx_rp + 3'h1;
    end
    if (rx_push) begin
      st_nxt.rx_mem[st_r.rx_wp] = {i_rx_err, i_rx_data};
      st_nxt.rx_wp = st_r.rx_wp + 3'h1;
    end
    st_nxt.rx_cnt = st_r.rx_cnt + {3'h0, rx_push} - {3'h0, rx_pop};
    if (tx_pop) begin
      st_nxt.tx_rp = st_r.tx_rp + 3'h1;
    end
    if (tx_push) begin
      st_nxt.tx_mem[st_r.tx_wp] = i_pwdata[7:0];
      st_nxt.tx_wp = st_r.tx_wp + 3'h1;
    end
    st_nxt.tx_cnt = st_r.tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop};
    // Flow control: negate on a start bit with no room, reassert once a slot frees.
    if (st_r.mr1[7] && i_rx_start && (st_r.rx_cnt == FIFO_FULL) && !rx_pop) begin
      st_nxt.rts_n = 1'b1;
      st_nxt.rts_auto = 1'b1;
    end else if (st_r.rts_auto && (st_nxt.rx_cnt != FIFO_FULL)) begin
      st_nxt.rts_n = 1'b0;
      st_nxt.rts_auto = 1'b0;
    end
    if (wr_acc && (i_paddr == OFS_CMD)) begin
      if (i_pwdata[0]) begin
        st_nxt.rx_en = 1'b1;
      end
      if (i_pwdata[1]) begin
        st_nxt.rx_en = 1'b0;
      end
      if (i_pwdata[2]) begin
        st_nxt.tx_en = 1'b1;
      end
      if (i_pwdata[3]) begin
        st_nxt.tx_en = 1'b0;
      end
      case (cmd)
        CMD_PTR_MR1: st_nxt.ptr = PTR_RESET;
        CMD_PTR_MR0: st_nxt.ptr = 2'h0;
        CMD_RX_RESET: begin
          st_nxt.rx_en = 1'b0;
          st_nxt.rx_wp = 3'h0;
          st_nxt.rx_rp = 3'h0;
          st_nxt.rx_cnt = 4'h0;
          st_nxt.err_sticky = 1'b0;
        end
        CMD_TX_RESET: begin
          st_nxt.tx_en = 1'b0;
          st_nxt.tx_wp = 3'h0;
          st_nxt.tx_rp = 3'h0;
          st_nxt.tx_cnt = 4'h0;
        end
        CMD_ERR_RESET: st_nxt.err_sticky = 1'b0;
        CMD_RTS_ASSERT: st_nxt.rts_n = 1'b0;
        CMD_RTS_NEGATE: st_nxt.rts_n = 1'b1;
        CMD_REFRESH: st_nxt.winner = win_latch;
        default: st_nxt.ptr = st_nxt.ptr;
      endcase
    end
    // A byte with an error arriving with the clear still sets the block flag.
    if (rx_push && i_rx_err && st_r.mr1[5]) begin
      st_nxt.err_sticky = 1'b1;
    end
    case (st_r.ack_state)
      ACK_IDLE: begin
        if (st_r.ack_q && !st_r.ack_s2) begin
          st_nxt.winner = win_latch;
          st_nxt.data = vector;
          st_nxt.data_oe_n = st_r.icw[1:0] == VFMT_NONE;
          st_nxt.ack_state = ACK_DRIVE;
        end
      end
      ACK_DRIVE: begin
        st_nxt.ack_n = 1'b0;
        st_nxt.ack_state = ACK_HOLD;
      end
      ACK_HOLD: begin
        st_nxt.ack_n = 1'b1;
        if (st_r.ack_s2) begin
          st_nxt.data_oe_n = 1'b1;
          st_nxt.ack_state = ACK_IDLE;
        end
      end
      default: st_nxt.ack_state = ACK_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= '{ptr: PTR_RESET, rts_n: 1'b1, winner: NO_WINNER, ack_s1: 1'b1, ack_s2: 1'b1,
        ack_q: 1'b1, ack_state: ACK_IDLE, data_oe_n: 1'b1, ack_n: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rx_bid = st_r.rx_en && (st_r.rx_cnt != 4'h0) && rx_level_ok;
  assign o_tx_bid = st_r.tx_en && tx_level_ok;
  assign o_prdata = st_r.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign o_tx_valid = st_r.tx_cnt != 4'h0;
  assign o_tx_data = st_r.tx_mem[st_r.tx_rp];
  assign o_data = st_r.data;
  assign o_data_oe_n = st_r.data_oe_n;
  assign o_bus_ack_pulse_n = st_r.ack_n;
  assign o_int_req = st_r.int_req;
  assign o_latched_winner_reg = st_r.winner;
  assign o_request_to_send_out_n = st_r.rts_n;
  assign o_rx_enabled = st_r.rx_en;
  assign o_tx_enabled = st_r.tx_en;
  assign o_watchdog_en = st_r.mr0_hi[3];
  assign o_rx_err = st_r.mr1[5] ? st_r.err_sticky
    : ((st_r.rx_cnt != 4'h0) && st_r.rx_mem[st_r.rx_rp][8]);
  assign o_parity_mode = st_r.mr1[4:3];
  assign o_parity_odd = st_r.mr1[2];
  assign o_char_bits = CHAR_BITS_MIN + {2'h0, st_r.mr1[1:0]};
  assign o_channel_mode = st_r.mr2[7:6];
  assign o_tx_send_request_control = st_r.mr2[5];
  assign o_cts_enable = st_r.mr2[4];
  // Long codes already start one bit later, so only short codes get the extra half bit.
  assign o_stop_sixteenths = st_r.mr2[3] ? STOP_LONG_BASE + {2'h0, st_r.mr2[3:0]}
    : STOP_SHORT_BASE + {3'h0, st_r.mr2[2:0]}
    + ((st_r.mr1[1:0] == CHAR_LEN_FIVE) ? STOP_FIVE_EXTRA : 6'h00);
  assign o_rx_clk_select = st_r.clksel[7:4];
  assign o_tx_clk_select = st_r.clksel[3:0];

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_ack_seen;
    st_r.ack_state == ACK_IDLE && st_r.ack_q && !st_r.ack_s2;
  endsequence
  sequence s_ack_pulse;
    ##1 o_bus_ack_pulse_n ##1 !o_bus_ack_pulse_n ##1 o_bus_ack_pulse_n;
  endsequence

  a_ack_pulse_once: assert property (s_ack_seen |-> s_ack_pulse)
    else $error("acknowledge pulse not produced after strobe");
  a_vector_float: assert property (s_ack_seen and (st_r.icw[1:0] == VFMT_NONE)
    |=> o_data_oe_n [*2])
    else $error("data bus driven with vector format none");
  a_vector_value: assert property (s_ack_seen |=> o_data == $past(vector))
    else $error("vector differs from selected format");
  a_rx_full_level: assert property (({st_r.mr0_hi[2], st_r.mr1[6]} == 2'b11)
    && (st_r.rx_cnt != FIFO_FULL) |-> !o_rx_bid)
    else $error("receiver bid below full level");
  a_tx_default_drop: assert property ((st_r.mr0_hi[1:0] == 2'b00) && tx_push
    && !tx_pop |=> !o_tx_bid)
    else $error("transmitter bid kept after load");
  a_tx_thresh_block: assert property (st_r.icw[7] && !o_rx_bid |=> !o_int_req)
    else $error("transmitter raised request above threshold");
  a_rx_accept_eight: assert property (i_rx_valid && st_r.rx_en && (st_r.rx_cnt < FIFO_FULL)
    && !rx_pop && !wr_acc |=> st_r.rx_cnt == $past(st_r.rx_cnt) + 4'h1)
    else $error("receive FIFO refused a byte");
  a_tx_no_load: assert property (!st_r.tx_en && wr_acc && (i_paddr == OFS_TXDATA)
    && !i_tx_take |=> st_r.tx_cnt == $past(st_r.tx_cnt))
    else $error("disabled transmitter loaded");
  a_ptr_sticks: assert property ((st_r.ptr == PTR_LAST) && !(wr_acc && (i_paddr == OFS_CMD))
    |=> st_r.ptr == PTR_LAST)
    else $error("mode pointer left 2 without command");
  a_mr0_low_ones: assert property (setup && (i_paddr == OFS_MODE) && (st_r.ptr == 2'h0)
    |=> o_prdata[3:0] == MR0_LOW_READ)
    else $error("mode zero low bits not ones");
  a_rts_negate: assert property (st_r.mr1[7] && i_rx_start && (st_r.rx_cnt == FIFO_FULL)
    && !rx_pop |=> o_request_to_send_out_n)
    else $error("send request not negated when full");
endmodule : ucm_channel

// [rtl/ucm_pkg.sv]
// Constants and register map for the channel mode and interrupt vector block.
// Operation
// - Receiver bids at 1+, 3+, 6+ or 8 stored bytes per its level bits.
// - Transmitter bids at 8, 4+, 6+ or 1+ free positions per its level bits.
// - Reset leaves receive FIFO empty, transmit FIFO eight free; enabled transmitter bids.
// - Default transmit level withdraws the bid once one byte is loaded.
// - Levels gate bidding only; both FIFOs always hold eight bytes.
// - A disabled unit never bids, whatever its fill.
// - Transmitter bid top bit is zero, so thresholds from 100000 block it.
// - Acknowledge cycle drives an eight-bit vector and ends with an acknowledge pulse.
// - Vector format picks base, base plus channel, or base plus type and channel.
// - Format 11 drives no vector, keeps the bus floating, still pulses acknowledge.
// - Parity mode: with, forced, none, wake-up; parity type bit even or odd.
// - Character length codes select 5, 6, 7 or 8 data bits.
// - Block error mode keeps errors until error reset command or receiver reset.
// - Channel mode: normal, auto echo, local loopback, remote loopback.
// - Stop code gives 0.563 to 1.000 or 1.563 to 2.000 bits in sixteenths.
// - Five-bit characters add half a bit to stop codes 0 to 7.
// - Command low bits strobe enables and disables; high nibble is a command code.
// - A disabled transmitter ignores loads to its FIFO.
// - Mode pointer advances on every access and sticks at 2 until a pointer command or reset.
// - Reading mode register zero returns ones in its low four bits.
// - Mode zero bit 7 enables the receive FIFO watchdog timer.
// - Receiver flow control negates send request on start bit when full, reasserts later.
package ucm_pkg;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CLKSEL = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_ICW = 8'h0C;
  localparam logic [7:0] OFS_VBASE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_TXDATA = 8'h18;
  localparam logic [7:0] OFS_RXDATA = 8'h1C;
  localparam logic [7:0] OFS_WINNER = 8'h20;
  localparam logic [3:0] CMD_PTR_MR1 = 4'h1;
  localparam logic [3:0] CMD_RX_RESET = 4'h2;
  localparam logic [3:0] CMD_TX_RESET = 4'h3;
  localparam logic [3:0] CMD_ERR_RESET = 4'h4;
  localparam logic [3:0] CMD_RTS_ASSERT = 4'h8;
  localparam logic [3:0] CMD_RTS_NEGATE = 4'h9;
  localparam logic [3:0] CMD_PTR_MR0 = 4'hB;
  localparam logic [3:0] CMD_REFRESH = 4'hC;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FIFO_FULL = 4'h8;
  localparam logic [1:0] PTR_RESET = 2'h1;
  localparam logic [1:0] PTR_LAST = 2'h2;
  localparam logic [3:0] MR0_LOW_READ = 4'hF;
  localparam logic [7:0] NO_WINNER = 8'hFF;
  localparam logic [1:0] VFMT_BASE = 2'h0;
  localparam logic [1:0] VFMT_CHAN = 2'h1;
  localparam logic [1:0] VFMT_TYPE = 2'h2;
  localparam logic [1:0] VFMT_NONE = 2'h3;
  localparam logic [2:0] TYPE_TX = 3'h1;
  localparam logic [1:0] TYPE_RX_LOW = 2'h3;
  localparam logic [3:0] RX_LVL_3 = 4'h3;
  localparam logic [3:0] RX_LVL_6 = 4'h6;
  localparam logic [3:0] TX_LVL_4 = 4'h4;
  localparam logic [3:0] TX_LVL_6 = 4'h6;
  localparam logic [5:0] STOP_SHORT_BASE = 6'h09;
  localparam logic [5:0] STOP_LONG_BASE = 6'h11;
  localparam logic [5:0] STOP_FIVE_EXTRA = 6'h08;
  localparam logic [3:0] CHAR_BITS_MIN = 4'h5;
  localparam logic [1:0] CHAR_LEN_FIVE = 2'h0;
endpackage : ucm_pkg

// [verification/ucm_host_ack.sv]
// Host model that runs one interrupt acknowledge cycle per request.
module ucm_host_ack (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_ack_n,
  input wire logic [7:0] i_bus,
  output logic o_strobe_n,
  output logic o_done,
  output logic [7:0] o_vec
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_strobe_n = 1'b1;
    o_done = 1'b0;
    o_vec = 8'h00;
    forever begin
      @(posedge i_clk);
      o_done <= 1'b0;
      if (i_go) begin
        o_strobe_n <= 1'b0;
        // The host never ends the cycle itself; the bench watchdog guards a dead device.
        do begin
          @(posedge i_clk);
        end while (i_ack_n !== 1'b0);
        o_vec <= i_bus;
        o_strobe_n <= 1'b1;
        repeat (6) @(posedge i_clk);
        o_done <= 1'b1;
      end
    end
  end
endmodule : ucm_host_ack

// [verification/test_uart_channel_mode_and_vector.sv]
// Self-checking bench for the channel mode and interrupt vector block.
module test_uart_channel_mode_and_vector;
  timeunit 1ns;
  timeprecision 1ns;
  import ucm_pkg::*;
  localparam logic [1:0] CH = 2'h2;
  localparam logic [7:0] WIN = {3'h3, TYPE_TX, CH};
  logic i_mclk, i_rstn, i_psel, i_penable, i_pwrite, i_rx_valid, i_rx_err, i_rx_start;
  logic i_tx_take, i_int_ack_strobe_n, o_pready, o_pslverr, o_tx_valid, o_data_oe_n;
  logic o_bus_ack_pulse_n, o_int_req, o_rx_bid, o_tx_bid, o_request_to_send_out_n;
  logic o_rx_enabled, o_tx_enabled, o_watchdog_en, o_rx_err, o_parity_odd;
  logic o_tx_send_request_control, o_cts_enable, go, done, slverr;
  logic [1:0] o_parity_mode, o_channel_mode, en;
  logic [3:0] o_char_bits, o_rx_clk_select, o_tx_clk_select;
  logic [5:0] o_stop_sixteenths;
  logic [7:0] i_paddr, i_rx_data, o_tx_data, o_data, o_latched_winner_reg;
  logic [7:0] vec, m0, m1, m2, cs;
  logic [31:0] i_pwdata, o_prdata, q;
  logic [7:0] txq[$];
  int err_count = 0;
  int cmp_count = 0;
  int n;
  wire logic [7:0] dbus = o_data_oe_n ? 8'hzz : o_data;

  ucm_channel #(.CHANNEL(CH)) dut (.i_mclk, .i_rstn, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rx_valid, .i_rx_data,
    .i_rx_err, .i_rx_start, .i_tx_take, .o_tx_valid, .o_tx_data, .i_int_ack_strobe_n,
    .o_data, .o_data_oe_n, .o_bus_ack_pulse_n, .o_int_req, .o_rx_bid, .o_tx_bid,
    .o_latched_winner_reg, .o_request_to_send_out_n, .o_rx_enabled, .o_tx_enabled,
    .o_watchdog_en, .o_rx_err, .o_parity_mode, .o_parity_odd, .o_char_bits,
    .o_channel_mode, .o_tx_send_request_control, .o_cts_enable, .o_stop_sixteenths,
    .o_rx_clk_select, .o_tx_clk_select);
  ucm_host_ack host (.i_clk(i_mclk), .i_go(go), .i_ack_n(o_bus_ack_pulse_n), .i_bus(dbus),
    .o_strobe_n(i_int_ack_strobe_n), .o_done(done), .o_vec(vec));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {24'h00_0000, d};
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_mclk);
    end while (o_pready !== 1'b1);
    q = o_prdata;
    slverr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic cmd(input logic [7:0] c);
    apb(1'b1, OFS_CMD, c);
    repeat (2) @(posedge i_mclk);
  endtask : cmd

  // Reprograms both level fields; mode one gets the extra bits given.
  task automatic lv(input logic [1:0] r, input logic [1:0] t, input logic [7:0] x);
    cmd({CMD_PTR_MR0, 4'h0});
    apb(1'b1, OFS_MODE, {1'b0, r[1], t, 4'h0});
    apb(1'b1, OFS_MODE, x | {1'b0, r[0], 6'h00});
  endtask : lv

  task automatic push(input logic e);
    @(posedge i_mclk);
    i_rx_valid <= 1'b1;
    i_rx_data <= 8'($urandom);
    i_rx_err <= e;
    @(posedge i_mclk);
    i_rx_valid <= 1'b0;
    @(negedge i_mclk);
  endtask : push

  function automatic logic rx_exp(input logic [1:0] l, input int c);
    return c >= (l == 2'h0 ? 1 : l == 2'h1 ? 3 : l == 2'h2 ? 6 : 8);
  endfunction : rx_exp

  function automatic logic tx_exp(input logic [1:0] l, input int f);
    return l == 2'h0 ? f == 8 : f >= (l == 2'h1 ? 4 : l == 2'h2 ? 6 : 1);
  endfunction : tx_exp

  function automatic logic [5:0] stop_exp(input logic [7:0] a, input logic [7:0] b);
    return {2'h0, b[3:0]} + (b[3] ? 6'h11 : 6'h09) + ((!b[3] && a[1:0] == 2'h0) ? 6'h08 : 6'h00);
  endfunction : stop_exp

  function automatic logic [7:0] vec_exp(input logic [1:0] f, input logic [7:0] b);
    case (f)
      2'h0: return b;
      2'h1: return {b[7:2], WIN[1:0]};
      2'h2: return {b[7:5], WIN[4:0]};
      default: return 8'hzz;
    endcase
  endfunction : vec_exp

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  initial begin
    repeat (30000) @(posedge i_mclk);
    err_count++;
    finish_test;
  end

  initial begin
    {i_rstn, i_psel, i_penable, i_pwrite, i_rx_valid, i_rx_err, i_rx_start} = 7'h00;
    {i_tx_take, go, i_paddr, i_pwdata, i_rx_data} = 50'h0;
    void'($urandom(53));
    repeat (12) @(posedge i_mclk);
    i_rstn <= 1'b1;
    @(negedge i_mclk);
    chk({o_tx_bid, o_rx_bid, o_latched_winner_reg}, {2'h0, NO_WINNER});
    for (int k = 0; k < 6; k++) begin
      {m0, m1, m2, cs} = $urandom;
      if (k < 2) begin
        m1[1:0] = 2'h0;
        m2[3:0] = k ? 4'h8 : 4'h7;
      end
      cmd({CMD_PTR_MR0, 4'h0});
      apb(1'b1, OFS_MODE, m0);
      apb(1'b1, OFS_MODE, m1);
      apb(1'b1, OFS_MODE, ~m2);
      apb(1'b1, OFS_MODE, m2);
      apb(1'b1, OFS_CLKSEL, cs);
      apb(1'b0, OFS_MODE, 8'h00);
      chk(q, m2);
      cmd({CMD_PTR_MR0, 4'h0});
      apb(1'b0, OFS_MODE, 8'h00);
      chk(q, {m0[7:4], MR0_LOW_READ});
      apb(1'b0, OFS_MODE, 8'h00);
      chk(q, m1);
      chk(o_watchdog_en, m0[7]);
      chk({o_parity_mode, o_parity_odd}, m1[4:2]);
      chk(o_char_bits, {2'h0, m1[1:0]} + CHAR_BITS_MIN);
      chk({o_channel_mode, o_tx_send_request_control, o_cts_enable}, m2[7:4]);
      chk(o_stop_sixteenths, stop_exp(m1, m2));
      chk({o_rx_clk_select, o_tx_clk_select}, cs);
    end
    apb(1'b0, OFS_CMD, 8'h00);
    chk(q, 32'h0000_0000);
    apb(1'b0, 8'h24, 8'h00);
    chk({slverr, q[7:0]}, 9'h100);
    en = 2'h0;
    for (int k = 0; k < 12; k++) begin
      m0 = {4'h0, 4'($urandom)};
      cmd(m0);
      en[0] = m0[1] ? 1'b0 : (m0[0] | en[0]);
      en[1] = m0[3] ? 1'b0 : (m0[2] | en[1]);
      chk({o_tx_enabled, o_rx_enabled}, en);
    end
    // A mid-run reset must disable both units and put the pointer back on mode one.
    i_rstn <= 1'b0;
    @(posedge i_mclk);
    i_rstn <= 1'b1;
    apb(1'b1, OFS_MODE, 8'h03);
    @(negedge i_mclk);
    chk({o_tx_enabled, o_rx_enabled, o_char_bits}, 6'h08);
    cmd(8'h08);
    apb(1'b1, OFS_TXDATA, 8'h5A);
    @(negedge i_mclk);
    chk(o_tx_valid, 1'b0);
    lv(2'h0, 2'h0, 8'h00);
    cmd({CMD_RX_RESET, 4'h0});
    cmd(8'h05);
    apb(1'b1, OFS_ICW, 8'h00);
    @(negedge i_mclk);
    chk(o_tx_bid, 1'b1);
    cmd({CMD_REFRESH, 4'h0});
    apb(1'b0, OFS_WINNER, 8'h00);
    chk(q, WIN);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OFS_ICW, k == 0 ? 8'h60 : k == 1 ? 8'h64 : 8'h80);
      repeat (3) @(negedge i_mclk);
      chk(o_int_req, k == 0);
    end
    for (int f = 0; f < 4; f++) begin
      m0 = 8'($urandom);
      apb(1'b1, OFS_VBASE, m0);
      apb(1'b1, OFS_ICW, 8'(f));
      @(posedge i_mclk);
      go <= 1'b1;
      @(posedge i_mclk);
      go <= 1'b0;
      do begin
        @(posedge i_mclk);
      end while (done !== 1'b1);
      chk(vec, vec_exp(2'(f), m0));
      chk(o_latched_winner_reg, WIN);
    end
    for (int l = 0; l < 4; l++) begin
      lv(2'h0, 2'(l), 8'h00);
      cmd({CMD_TX_RESET, 4'h0});
      cmd(8'h04);
      txq.delete();
      for (int w = 0; w <= 9; w++) begin
        @(negedge i_mclk);
        chk(o_tx_bid, tx_exp(2'(l), w < 8 ? 8 - w : 0));
        m0 = 8'($urandom);
        if (w < 8) txq.push_back(m0);
        if (w < 9) apb(1'b1, OFS_TXDATA, m0);
      end
      n = 0;
      while (o_tx_valid === 1'b1 && n < 12) begin
        chk(o_tx_data, n < 8 ? txq[n] : 8'h00);
        @(posedge i_mclk);
        i_tx_take <= 1'b1;
        @(posedge i_mclk);
        i_tx_take <= 1'b0;
        @(negedge i_mclk);
        n++;
      end
      chk(n, 8);
    end
    for (int l = 0; l < 4; l++) begin
      lv(2'(l), 2'h0, 8'h80);
      cmd({CMD_RX_RESET, 4'h0});
      cmd(8'h01);
      cmd({CMD_RTS_ASSERT, 4'h0});
      for (int w = 1; w <= 9; w++) begin
        push(1'b0);
        chk(o_rx_bid, rx_exp(2'(l), w));
      end
    end
    chk(o_request_to_send_out_n, 1'b0);
    apb(1'b0, OFS_STATUS, 8'h00);
    chk(q, 32'h0000_007E);
    @(posedge i_mclk);
    i_rx_start <= 1'b1;
    @(posedge i_mclk);
    i_rx_start <= 1'b0;
    repeat (2) @(negedge i_mclk);
    chk(o_request_to_send_out_n, 1'b1);
    apb(1'b0, OFS_RXDATA, 8'h00);
    repeat (2) @(negedge i_mclk);
    chk(o_request_to_send_out_n, 1'b0);
    lv(2'h0, 2'h0, 8'h20);
    cmd({CMD_RX_RESET, 4'h0});
    cmd(8'h01);
    push(1'b1);
    apb(1'b0, OFS_RXDATA, 8'h00);
    @(negedge i_mclk);
    chk(o_rx_err, 1'b1);
    cmd({CMD_ERR_RESET, 4'h0});
    chk(o_rx_err, 1'b0);
    finish_test;
  end
endmodule : test_uart_channel_mode_and_vector
